// ### logic/ddc_drive_control.sv
// Drive device-control state machine with motor and encoder data entries
`include "ddc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module ddc_drive_control #(
	parameter logic [1:0]  VARIANT       = 2'h0,
	parameter logic [15:0] SPEED_CONST   = 16'h0000,
	parameter logic [15:0] TERM_RES      = 16'h0000,
	parameter logic [15:0] POLE_COUNT    = 16'h0002,
	parameter logic [15:0] THERM_CONST   = 16'h0000,
	parameter logic [31:0] ABS_COUNTS    = 32'h0000_1000
) (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	// Object dictionary access
	input  wire ddc_pkg::ddc_od_req_t od_req,
	output var  ddc_pkg::ddc_od_rsp_t od_rsp,
	// Drive conditions
	input  wire logic                 supply_ok,
	input  wire logic                 masked_error,
	input  wire logic                 stop_done,
	// Drive control and status
	output var  ddc_pkg::ddc_drive_t  drive,
	output logic [15:0]               status_word,
	output logic [31:0]               counts_per_rev,
	output logic [7:0]                sensor_select
);

	//----------------------------------------------------------------
	// Object decode
	//----------------------------------------------------------------
	logic [15:0]         cw_r;
	logic [15:0]         sd_opt_r;
	logic [15:0]         do_opt_r;
	logic [15:0]         speed_r;
	logic [15:0]         tres_r;
	logic [15:0]         poles_r;
	logic [15:0]         therm_r;
	logic [7:0]          sens_r;
	logic [31:0]         ext_cnt_r;
	ddc_pkg::ddc_state_t state_r;
	ddc_pkg::ddc_state_t state_nxt;
	ddc_pkg::ddc_state_t tgt_r;
	ddc_pkg::ddc_state_t tgt_nxt;
	logic [15:0]         sw_nxt;
	ddc_pkg::ddc_drive_t drv_nxt;
	ddc_pkg::ddc_od_rsp_t rsp_nxt;

	wire is_motor  = od_req.index == `DDC_IDX_MOTOR;
	wire is_enc    = od_req.index == `DDC_IDX_ENCODER;
	wire hit_mcnt  = is_motor && od_req.sub == `DDC_SUB_0;
	wire hit_speed = is_motor && od_req.sub == `DDC_SUB_1;
	wire hit_tres  = is_motor && od_req.sub == `DDC_SUB_2;
	wire hit_poles = is_motor && od_req.sub == `DDC_SUB_3;
	wire hit_therm = is_motor && od_req.sub == `DDC_SUB_5;
	wire hit_ecnt  = is_enc && od_req.sub == `DDC_SUB_0;
	wire hit_sens  = is_enc && od_req.sub == `DDC_SUB_1;
	wire hit_ext   = is_enc && od_req.sub == `DDC_SUB_2;
	wire hit_hall  = is_enc && od_req.sub == `DDC_SUB_3;
	wire hit_cw    = od_req.index == `DDC_IDX_CTRL && od_req.sub == `DDC_SUB_0;
	wire hit_sw    = od_req.index == `DDC_IDX_STATUS && od_req.sub == `DDC_SUB_0;
	wire hit_sdo   = od_req.index == `DDC_IDX_SD_OPT && od_req.sub == `DDC_SUB_0;
	wire hit_doo   = od_req.index == `DDC_IDX_DO_OPT && od_req.sub == `DDC_SUB_0;

	wire hit_any   = hit_mcnt | hit_speed | hit_tres | hit_poles | hit_therm | hit_ecnt | hit_sens
		| hit_ext | hit_hall | hit_cw | hit_sw | hit_sdo | hit_doo;
	// Entry counts, Hall counts and status are fixed for software
	wire hit_ro    = hit_mcnt | hit_ecnt | hit_hall | hit_sw; // R17

	// Sensor changeover only on the brushless variant
	wire [7:0] sens_w = od_req.wdata[7:0];
	wire sens_legal = (VARIANT == `DDC_VAR_BRUSHLESS) && od_req.wdata[31:8] == 24'h000000
		&& (sens_w == `DDC_SENS_HALL || sens_w == `DDC_SENS_INC || sens_w == `DDC_SENS_INC_HALL); // R19
	// Absolute variant cannot use an external encoder
	wire ext_legal  = VARIANT != `DDC_VAR_ABS; // R19
	// Sixteen-bit entries refuse a write with upper bits set
	wire hit_16     = hit_speed | hit_tres | hit_poles | hit_therm | hit_cw | hit_sdo | hit_doo;
	wire wide_bad   = hit_16 && od_req.wdata[31:16] != 16'h0000;

	wire wr_ok  = od_req.req && od_req.wr && hit_any && !hit_ro
		&& !(hit_sens && !sens_legal) && !(hit_ext && !ext_legal) && !wide_bad;
	wire rd_ok  = od_req.req && !od_req.wr && hit_any;
	wire wr_cw  = wr_ok && hit_cw;
	wire wr_16  = wr_ok && od_req.wdata[31:16] == 16'h0000;

	// Unmapped reads are aborted and keep the previous read data
	wire [31:0] rd_data =
		hit_mcnt  ? {24'h000000, `DDC_MOTOR_ENTRIES} :
		hit_speed ? {16'h0000, speed_r} :
		hit_tres  ? {16'h0000, tres_r} :
		hit_poles ? {16'h0000, poles_r} :
		hit_therm ? {16'h0000, therm_r} :
		hit_ecnt  ? {24'h000000, `DDC_ENC_ENTRIES} :
		hit_sens  ? {24'h000000, sens_r} :
		hit_ext   ? ext_cnt_r :
		hit_hall  ? `DDC_HALL_CNT :
		hit_cw    ? {16'h0000, cw_r} :
		hit_sw    ? {16'h0000, status_word} :
		hit_sdo   ? {16'h0000, sd_opt_r} :
		hit_doo   ? {16'h0000, do_opt_r} : 32'h0000_0000;

	always_comb begin
		rsp_nxt.ack   = od_req.req;
		rsp_nxt.abort = od_req.req && !(wr_ok || rd_ok);
		rsp_nxt.rdata = rd_ok ? rd_data : od_rsp.rdata;
	end

	//----------------------------------------------------------------
	// Entry storage
	//----------------------------------------------------------------
	// Reset sensor follows the variant; only the brushless variant can change it later
	wire [7:0] sens_rst = (VARIANT == `DDC_VAR_DC) ? `DDC_SENS_INC :
		(VARIANT == `DDC_VAR_ABS) ? `DDC_SENS_ABS : `DDC_SENS_HALL; // R19

	// One short process per entry; refused writes never reach them
	always_ff @(posedge core_clk) begin
		if (reset)
			cw_r <= 16'h0000;
		else if (wr_cw && wr_16)
			cw_r <= od_req.wdata[15:0];
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			sd_opt_r <= `DDC_OPT_RST;
		else if (wr_16 && hit_sdo)
			sd_opt_r <= od_req.wdata[15:0];
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			do_opt_r <= `DDC_OPT_RST;
		else if (wr_16 && hit_doo)
			do_opt_r <= od_req.wdata[15:0];
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			speed_r <= SPEED_CONST;
		else if (wr_16 && hit_speed)
			speed_r <= od_req.wdata[15:0];
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			tres_r <= TERM_RES;
		else if (wr_16 && hit_tres)
			tres_r <= od_req.wdata[15:0];
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			poles_r <= POLE_COUNT;
		else if (wr_16 && hit_poles)
			poles_r <= od_req.wdata[15:0];
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			therm_r <= THERM_CONST;
		else if (wr_16 && hit_therm)
			therm_r <= od_req.wdata[15:0];
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			sens_r <= sens_rst;
		else if (wr_ok && hit_sens)
			sens_r <= sens_w; // R16
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			ext_cnt_r <= `DDC_EXT_CNT_RST; // R18
		else if (wr_ok && hit_ext)
			ext_cnt_r <= od_req.wdata;
	end

	// Answer always one cycle after the request
	always_ff @(posedge core_clk) begin
		if (reset)
			od_rsp <= '0;
		else
			od_rsp <= rsp_nxt;
	end

	// Feedback resolution follows the selected sensor
	always_ff @(posedge core_clk) begin
		if (reset) begin
			counts_per_rev <= 32'h0000_0000;
			sensor_select  <= 8'h00;
		end else begin
			sensor_select  <= sens_r;
			counts_per_rev <= (sens_r == `DDC_SENS_HALL) ? `DDC_HALL_CNT : // R17
				(sens_r == `DDC_SENS_ABS) ? ABS_COUNTS : ext_cnt_r; // R16 R18
		end
	end

	//----------------------------------------------------------------
	// Command decode
	//----------------------------------------------------------------
	// Control word 16 bits wide; an over-wide write is refused and not decoded
	wire       cmd_v   = wr_cw && wr_16;
	wire [3:0] cmd     = od_req.wdata[`DDC_CW_CMD];
	wire cmd_dv  = cmd_v && !cmd[1]; // R15
	wire cmd_qs  = cmd_v && cmd[1] && !cmd[2];
	wire cmd_sd  = cmd_v && cmd[2:0] == `DDC_CMD_SHUTDOWN;
	wire cmd_so  = cmd_v && cmd == `DDC_CMD_SWON;
	wire cmd_eo  = cmd_v && cmd == `DDC_CMD_ENOP;
	// Only a rising edge acknowledges; holding the bit high does nothing
	wire cmd_fr  = cmd_v && od_req.wdata[`DDC_CW_FRESET] && !cw_r[`DDC_CW_FRESET]; // R21

	// Running states need a stop ramp before the stage goes off
	wire running = state_r == ddc_pkg::DDC_OP_EN || state_r == ddc_pkg::DDC_QS_ACTIVE
		|| state_r == ddc_pkg::DDC_STOPPING;
	wire sd_brake = sd_opt_r != 16'h0000;
	wire do_brake = do_opt_r != 16'h0000;
	// Enable through switched on in one extra cycle
	logic auto_en_r;
	wire  auto_en_nxt = state_r == ddc_pkg::DDC_READY && cmd_eo && supply_ok;

	//----------------------------------------------------------------
	// State machine
	//----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		tgt_nxt   = tgt_r;
		// Any state except not-ready and those already in fault handling; R24 input used as is
		if (masked_error && state_r != ddc_pkg::DDC_FAULT && state_r != ddc_pkg::DDC_FAULT_REACT // R24
			&& state_r != ddc_pkg::DDC_NOT_READY) begin
			state_nxt = running ? ddc_pkg::DDC_FAULT_REACT : ddc_pkg::DDC_FAULT; // R12
		end else begin
			// Undefined command/state pairs fall through unchanged
			case (state_r) // R22 R23 R14
				ddc_pkg::DDC_NOT_READY: begin
					state_nxt = ddc_pkg::DDC_SWON_DIS; // R01
				end
				ddc_pkg::DDC_SWON_DIS: begin
					if (cmd_sd)
						state_nxt = ddc_pkg::DDC_READY; // R02
				end
				ddc_pkg::DDC_READY: begin
					if (cmd_dv || cmd_qs)
						state_nxt = ddc_pkg::DDC_SWON_DIS;
					else if (cmd_so)
						state_nxt = ddc_pkg::DDC_SWITCHED_ON; // R03
					else if (cmd_eo && supply_ok)
						state_nxt = ddc_pkg::DDC_SWITCHED_ON; // R04 R05
				end
				ddc_pkg::DDC_SWITCHED_ON: begin
					if (cmd_dv || cmd_qs)
						state_nxt = ddc_pkg::DDC_SWON_DIS;
					else if (cmd_sd)
						state_nxt = ddc_pkg::DDC_READY;
					else if ((cmd_eo || auto_en_r) && supply_ok)
						state_nxt = ddc_pkg::DDC_OP_EN; // R04 R05
				end
				ddc_pkg::DDC_OP_EN: begin
					if (cmd_dv) begin
						state_nxt = ddc_pkg::DDC_SWON_DIS; // R08
					end else if (cmd_qs) begin
						state_nxt = ddc_pkg::DDC_QS_ACTIVE; // R09
					end else if (cmd_sd) begin
						state_nxt = sd_brake ? ddc_pkg::DDC_STOPPING : ddc_pkg::DDC_READY; // R02
						tgt_nxt   = ddc_pkg::DDC_READY;
					end else if (cmd_so) begin
						state_nxt = do_brake ? ddc_pkg::DDC_STOPPING : ddc_pkg::DDC_SWITCHED_ON; // R07
						tgt_nxt   = ddc_pkg::DDC_SWITCHED_ON;
					end
				end
				ddc_pkg::DDC_STOPPING: begin
					// Disable voltage cuts the ramp short
					if (cmd_dv)
						state_nxt = ddc_pkg::DDC_SWON_DIS; // R08
					else if (stop_done)
						state_nxt = tgt_r;
				end
				ddc_pkg::DDC_QS_ACTIVE: begin
					if (cmd_dv)
						state_nxt = ddc_pkg::DDC_SWON_DIS; // R10
				end
				ddc_pkg::DDC_FAULT_REACT: begin
					if (stop_done)
						state_nxt = ddc_pkg::DDC_FAULT; // R12
				end
				ddc_pkg::DDC_FAULT: begin
					// Only a fresh acknowledgement leaves fault
					if (cmd_fr)
						state_nxt = ddc_pkg::DDC_SWON_DIS; // R13
				end
				default: begin
					state_nxt = ddc_pkg::DDC_FAULT;
				end
			endcase
		end
	end

	//----------------------------------------------------------------
	// Outputs
	//----------------------------------------------------------------
	wire nxt_op   = state_nxt == ddc_pkg::DDC_OP_EN;
	wire nxt_qs   = state_nxt == ddc_pkg::DDC_QS_ACTIVE;
	wire nxt_stop = state_nxt == ddc_pkg::DDC_STOPPING || state_nxt == ddc_pkg::DDC_FAULT_REACT;
	wire nxt_on   = nxt_op || state_nxt == ddc_pkg::DDC_STOPPING || nxt_qs;
	// Leaving operation enabled toward switched on or quick stop discards jobs
	wire flush    = state_r == ddc_pkg::DDC_OP_EN && (nxt_qs
		|| state_nxt == ddc_pkg::DDC_SWITCHED_ON
		|| (state_nxt == ddc_pkg::DDC_STOPPING && tgt_nxt == ddc_pkg::DDC_SWITCHED_ON)); // R07 R09
	// Halt follows a control word written in this cycle
	wire cw_nxt_halt = cmd_v ? od_req.wdata[`DDC_CW_HALT] : cw_r[`DDC_CW_HALT];

	always_comb begin
		// Stage stays on in operation enabled, in quick stop active and while a stop ramp still needs torque
		drv_nxt.power_stage_en   = nxt_on || state_nxt == ddc_pkg::DDC_FAULT_REACT; // R06 R08 R12
		drv_nxt.mode_run_en      = nxt_op; // R06
		drv_nxt.controlled_stop  = nxt_stop; // R02 R07 R12
		drv_nxt.quick_ramp       = nxt_qs; // R09
		// Halt only suspends; the queue is kept
		drv_nxt.job_hold         = nxt_op && cw_nxt_halt; // R11
		drv_nxt.job_flush        = flush;
		drv_nxt.led_flash_green  = state_nxt == ddc_pkg::DDC_SWON_DIS; // R01
		drv_nxt.led_steady_green = nxt_op; // R06
	end

	//----------------------------------------------------------------
	// Status word
	//----------------------------------------------------------------
	wire in_rdy = state_nxt == ddc_pkg::DDC_READY || state_nxt == ddc_pkg::DDC_SWITCHED_ON || nxt_on;
	wire in_swn = state_nxt == ddc_pkg::DDC_SWITCHED_ON || nxt_on;
	wire in_flt = state_nxt == ddc_pkg::DDC_FAULT || state_nxt == ddc_pkg::DDC_FAULT_REACT;

	always_comb begin
		sw_nxt                = 16'h0000;
		sw_nxt[`DDC_SW_RDY]   = in_rdy; // R15
		sw_nxt[`DDC_SW_SWON]  = in_swn;
		sw_nxt[`DDC_SW_OPEN]  = nxt_on;
		sw_nxt[`DDC_SW_FAULT] = in_flt;
		sw_nxt[`DDC_SW_VOLT]  = in_rdy;
		sw_nxt[`DDC_SW_QS_N]  = !nxt_qs;
		sw_nxt[`DDC_SW_DIS]   = state_nxt == ddc_pkg::DDC_SWON_DIS;
	end

	//----------------------------------------------------------------
	// Registers
	//----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_r   <= ddc_pkg::DDC_NOT_READY; // R01
			tgt_r     <= ddc_pkg::DDC_READY;
			auto_en_r <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			tgt_r     <= tgt_nxt;
			auto_en_r <= auto_en_nxt;
		end
	end

	// Built from the next state so outputs change on the edge of the ack
	always_ff @(posedge core_clk) begin
		if (reset) begin
			drive       <= '0;
			status_word <= 16'h0000;
		end else begin
			drive       <= drv_nxt;
			status_word <= sw_nxt;
		end
	end

endmodule
`default_nettype wire

// ### logic/ddc_defines.svh
// Constants of the drive device-control block: object indices, fields, reset values
//----------------------------------------------------------------
// Contract
// R01 - After reset, pass not-ready automatically and settle in switch-on disabled, flashing green.
// R02 - Shutdown goes to ready-to-switch-on; stop-option code selects a controlled stop first.
// R03 - Switch on in ready-to-switch-on moves to switched on.
// R04 - Enable operation in ready-to-switch-on passes switched on automatically to operation enabled.
// R05 - Operation enabled is entered only with supply in range; else state unchanged.
// R06 - Output stage on only in operation enabled, steady green, operating mode runs. Code also keeps it on in quick stop, stop ramps and fault reaction.
// R07 - Disable operation returns to switched on, cancels jobs; option selects controlled stop.
// R08 - Disable voltage turns output stage off at once, no braking, to switch-on disabled.
// R09 - Quick stop in operation enabled: quick stop active, quick ramp, discard jobs.
// R10 - Quick stop active is left only by disable voltage.
// R11 - Halt bit suspends current and queued jobs without discarding; cleared bit resumes.
// R12 - Masked error enters fault from any state: stop running motor, then stage off. Code exempts not-ready.
// R13 - Fault must be acknowledged by fault reset before the drive switches on again.
// R14 - Commands map to the numbered transitions of the command table.
// R15 - Commands decode from control word bits 0-3; status word reports the state.
// R16 - Sensor select: 0 Hall, 1 incremental, 10 incremental plus Hall, 104 absolute.
// R17 - Hall feedback counts fixed 3000 per revolution; that entry is read-only.
// R18 - External encoder counts are four-edge counts per revolution, default 2048.
// R19 - Brushed variant external encoder only; absolute variant rejects external encoder.
// R20 - Master brings drive up with control words 0x0006, 0x0007, 0x000F in order.
// R21 - Fault reset is a 0 to 1 transition of control word bit 7 only.
// R22 - Only transitions defined for the present state are performed.
// R23 - Commands without a transition from the present state are ignored entirely.
// R24 - Supply-in-range and masked error are synchronous single-bit inputs.
//----------------------------------------------------------------
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH

// Object indices and subindices
`define DDC_IDX_MOTOR      16'h2350
`define DDC_IDX_ENCODER    16'h2351
`define DDC_IDX_CTRL       16'h6040
`define DDC_IDX_STATUS     16'h6041
`define DDC_IDX_SD_OPT     16'h605b
`define DDC_IDX_DO_OPT     16'h605c
`define DDC_SUB_0          8'h00
`define DDC_SUB_1          8'h01
`define DDC_SUB_2          8'h02
`define DDC_SUB_3          8'h03
`define DDC_SUB_5          8'h05

// Reset values
`define DDC_MOTOR_ENTRIES  8'h05
`define DDC_ENC_ENTRIES    8'h03
`define DDC_EXT_CNT_RST    32'h0000_0800
`define DDC_HALL_CNT       32'h0000_0bb8
`define DDC_OPT_RST        16'h0001

// Sensor select codes
`define DDC_SENS_HALL      8'h00
`define DDC_SENS_INC       8'h01
`define DDC_SENS_INC_HALL  8'h0a
`define DDC_SENS_ABS       8'h68

// Variants
`define DDC_VAR_BRUSHLESS  2'h0
`define DDC_VAR_DC         2'h1
`define DDC_VAR_ABS        2'h2

// Control word fields
`define DDC_CW_CMD         3:0
`define DDC_CW_FRESET      7
`define DDC_CW_HALT        8
`define DDC_CMD_SHUTDOWN   3'h6
`define DDC_CMD_SWON       4'h7
`define DDC_CMD_ENOP       4'hf

// Status word bit positions
`define DDC_SW_RDY         0
`define DDC_SW_SWON        1
`define DDC_SW_OPEN        2
`define DDC_SW_FAULT       3
`define DDC_SW_VOLT        4
`define DDC_SW_QS_N        5
`define DDC_SW_DIS         6

`endif

// ### logic/ddc_pkg.sv
// Types of the drive device-control block
`default_nettype none
package ddc_pkg;

	typedef enum logic [3:0] {
		DDC_NOT_READY   = 4'b0000,
		DDC_SWON_DIS    = 4'b0001,
		DDC_READY       = 4'b0010,
		DDC_SWITCHED_ON = 4'b0011,
		DDC_OP_EN       = 4'b0100,
		DDC_QS_ACTIVE   = 4'b0101,
		DDC_STOPPING    = 4'b0110,
		DDC_FAULT_REACT = 4'b0111,
		DDC_FAULT       = 4'b1000
	} ddc_state_t;

	typedef struct packed {
		logic        req;
		logic        wr;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] wdata;
	} ddc_od_req_t;

	typedef struct packed {
		logic        ack;
		logic        abort;
		logic [31:0] rdata;
	} ddc_od_rsp_t;

	typedef struct packed {
		logic power_stage_en;
		logic mode_run_en;
		logic controlled_stop;
		logic quick_ramp;
		logic job_hold;
		logic job_flush;
		logic led_flash_green;
		logic led_steady_green;
	} ddc_drive_t;

endpackage
`default_nettype wire

// ### tb/ddc_drive_control_props.sv
// Port-level checker for the drive device-control block
`timescale 1ns/100ps
`default_nettype none
module ddc_drive_control_props (
	// Clock and reset
	input wire logic                 core_clk,
	input wire logic                 reset,
	// Object access
	input wire ddc_pkg::ddc_od_req_t od_req,
	input wire ddc_pkg::ddc_od_rsp_t od_rsp,
	// Drive conditions
	input wire logic                 supply_ok,
	input wire logic                 masked_error,
	input wire logic                 stop_done,
	// Drive control and status
	input wire ddc_pkg::ddc_drive_t  drive,
	input wire logic [15:0]          status_word,
	input wire logic [31:0]          counts_per_rev,
	input wire logic [7:0]           sensor_select
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_ack_next_cycle: assert property (od_req.req |=> od_rsp.ack)
		else $error("no answer one cycle after request");
	a_ack_has_cause: assert property (od_rsp.ack |-> $past(od_req.req))
		else $error("answer without request");
	a_stage_only_open: assert property (drive.power_stage_en |-> status_word[2] || drive.controlled_stop)
		else $error("output stage on outside operation");
	a_steady_green: assert property (drive.led_steady_green |-> status_word[2] && status_word[5])
		else $error("steady green outside operation enabled");
	a_supply_gate: assert property ($rose(status_word[2]) && status_word[5] |-> $past(supply_ok))
		else $error("operation entered without supply");
	a_fault_entry: assert property (masked_error && status_word[6] |-> ##[1:2] status_word[3])
		else $error("masked error did not reach fault");
	a_fault_stage_off: assert property (status_word[3] && !drive.controlled_stop
		|-> !drive.power_stage_en && !drive.mode_run_en)
		else $error("stage on in fault");
	a_quick_ramp_state: assert property (drive.quick_ramp |-> drive.power_stage_en && !status_word[5])
		else $error("quick ramp outside quick stop");
	a_hold_in_run: assert property (drive.job_hold |-> drive.mode_run_en)
		else $error("halt outside operation");
	a_hall_counts: assert property (sensor_select == 8'h00 [*3] |-> counts_per_rev == 32'h0000_0bb8)
		else $error("hall resolution wrong");
endmodule

bind ddc_drive_control ddc_drive_control_props u_props (
	.core_clk(core_clk), .reset(reset), .od_req(od_req), .od_rsp(od_rsp),
	.supply_ok(supply_ok), .masked_error(masked_error), .stop_done(stop_done),
	.drive(drive), .status_word(status_word), .counts_per_rev(counts_per_rev),
	.sensor_select(sensor_select));
`default_nettype wire

// ### tb/ddc_master_model.sv
// Network master model issuing object accesses
`timescale 1ns/100ps
`default_nettype none
module ddc_master_model (
	// Clock
	input  wire logic                 core_clk,
	// Object access
	output var  ddc_pkg::ddc_od_req_t od_req,
	input  wire ddc_pkg::ddc_od_rsp_t od_rsp
);
	initial od_req = '0;

	// Request stands for exactly the one taking edge
	task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sb,
		input logic [31:0] wd, output logic ok, output logic ab, output logic [31:0] rd);
		@(negedge core_clk);
		od_req = '{1'b1, w, idx, sb, wd};
		@(negedge core_clk);
		ok = od_rsp.ack;
		ab = od_rsp.abort;
		rd = od_rsp.rdata;
		// Released fields flip so stale values never look valid
		od_req = '{1'b0, ~w, ~idx, ~sb, ~wd};
	endtask

	// Status is read before every command word
	task automatic command(input logic [15:0] cw, output logic ok, output logic ab);
		logic [31:0] rd;
		access(1'b0, 16'h6041, 8'h00, 32'h0, ok, ab, rd);
		access(1'b1, 16'h6040, 8'h00, {16'h0, cw}, ok, ab, rd);
	endtask
endmodule
`default_nettype wire

// ### tb/tb_drive_device_control_fsm.sv
// Self-checking testbench of the drive device-control block
`timescale 1ns/100ps
`default_nettype none
module tb_drive_device_control_fsm;
	logic                 core_clk = 1'b0;
	logic                 reset = 1'b1;
	logic                 supply_ok = 1'b0;
	logic                 masked_error = 1'b0;
	logic                 stop_done = 1'b0;
	ddc_pkg::ddc_od_req_t od_req;
	ddc_pkg::ddc_od_rsp_t od_rsp;
	ddc_pkg::ddc_drive_t  drive;
	logic [15:0]          status_word;
	logic [31:0]          counts_per_rev;
	logic [7:0]           sensor_select;
	logic                 ok;
	logic                 ab;
	logic [31:0]          rdv;
	int                   err_count = 0;
	int                   comparisons = 0;
	logic [15:0]          ridx [7] = '{16'h2350, 16'h2351, 16'h2351, 16'h2351, 16'h2351, 16'h605b, 16'h605c};
	logic [7:0]           rsub [7] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h00};
	logic [31:0]          rexp [7] = '{32'h5, 32'h3, 32'h0, 32'h800, 32'hbb8, 32'h1, 32'h1};
	logic [7:0]           scode [3] = '{8'h01, 8'h0a, 8'h00};
	logic [31:0]          scnt [3] = '{32'h1000, 32'h1000, 32'hbb8};

	always #2.5 core_clk = ~core_clk;

	ddc_drive_control uut (
		.core_clk(core_clk), .reset(reset), .od_req(od_req), .od_rsp(od_rsp),
		.supply_ok(supply_ok), .masked_error(masked_error), .stop_done(stop_done),
		.drive(drive), .status_word(status_word), .counts_per_rev(counts_per_rev),
		.sensor_select(sensor_select));

	ddc_master_model m (.core_clk(core_clk), .od_req(od_req), .od_rsp(od_rsp));

	//----------------------------------------------------------------
	// Access and compare tasks
	//----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (e !== g) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask

	task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
		input logic eab);
		m.access(w, i, s, d, ok, ab, rdv);
		chk("ack", 32'h1, {31'h0, ok});
		chk("abort", {31'h0, eab}, {31'h0, ab});
	endtask

	// Status compare leaves out the voltage bit, whose timing is free
	task automatic cw(input logic [15:0] v, input logic [15:0] e);
		m.command(v, ok, ab);
		chk("cmd ack", 32'h1, {31'h0, ok});
		chk("status", {16'h0, e}, {16'h0, status_word & 16'h006f});
	endtask

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	//----------------------------------------------------------------
	// Tests
	//----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		print_verdict();
	end

	initial begin
		repeat (3) @(negedge core_clk);
		reset = 1'b0;
		repeat (2) @(negedge core_clk);
		chk("status", 32'h60, {16'h0, status_word});
		chk("flash", 32'h1, {31'h0, drive.led_flash_green});
		for (int k = 0; k < 7; k++) begin
			od(1'b0, ridx[k], rsub[k], 32'h0, 1'b0);
			chk("rdata", rexp[k], rdv);
		end
		od(1'b1, 16'h2350, 8'h00, 32'h7, 1'b1);
		od(1'b1, 16'h2351, 8'h03, 32'h5, 1'b1);
		od(1'b1, 16'h2352, 8'h00, 32'h0, 1'b1);
		od(1'b1, 16'h2350, 8'h01, 32'h1_0000, 1'b1);
		od(1'b1, 16'h2351, 8'h01, 32'h68, 1'b1);
		od(1'b1, 16'h2351, 8'h01, 32'h5, 1'b1);
		od(1'b1, 16'h2351, 8'h02, 32'h1000, 1'b0);
		for (int k = 0; k < 3; k++) begin
			od(1'b1, 16'h2351, 8'h01, {24'h0, scode[k]}, 1'b0);
			repeat (2) @(negedge core_clk);
			chk("sensor", {24'h0, scode[k]}, {24'h0, sensor_select});
			chk("counts", scnt[k], counts_per_rev);
		end
		od(1'b1, 16'h605b, 8'h00, 32'h0, 1'b0);
		od(1'b1, 16'h605c, 8'h00, 32'h0, 1'b0);
		supply_ok = 1'b1;
		cw(16'h0006, 16'h21);
		cw(16'h0007, 16'h23);
		supply_ok = 1'b0;
		cw(16'h000f, 16'h23);
		supply_ok = 1'b1;
		cw(16'h000f, 16'h27);
		chk("stage", 32'h1, {31'h0, drive.power_stage_en});
		chk("green", 32'h1, {31'h0, drive.led_steady_green});
		chk("run", 32'h1, {31'h0, drive.mode_run_en});
		cw(16'h010f, 16'h27);
		chk("hold", 32'h1, {31'h0, drive.job_hold});
		cw(16'h000f, 16'h27);
		chk("hold", 32'h0, {31'h0, drive.job_hold});
		cw(16'h0007, 16'h23);
		chk("flush", 32'h1, {31'h0, drive.job_flush});
		chk("stage", 32'h0, {31'h0, drive.power_stage_en});
		cw(16'h0006, 16'h21);
		cw(16'h000f, 16'h23);
		@(negedge core_clk);
		chk("status", 32'h27, {16'h0, status_word & 16'h006f});
		cw(16'h000b, 16'h07);
		chk("ramp", 32'h1, {31'h0, drive.quick_ramp});
		chk("flush", 32'h1, {31'h0, drive.job_flush});
		cw(16'h000f, 16'h07);
		cw(16'h0006, 16'h07);
		cw(16'h0000, 16'h60);
		chk("stage", 32'h0, {31'h0, drive.power_stage_en});
		cw(16'h0007, 16'h60);
		cw(16'h0006, 16'h21);
		cw(16'h000f, 16'h23);
		@(negedge core_clk);
		masked_error = 1'b1;
		@(negedge core_clk);
		masked_error = 1'b0;
		@(negedge core_clk);
		chk("stop", 32'h1, {31'h0, drive.controlled_stop});
		chk("stage", 32'h1, {31'h0, drive.power_stage_en});
		stop_done = 1'b1;
		repeat (4) @(negedge core_clk);
		chk("status", 32'h28, {16'h0, status_word & 16'h006f});
		chk("stage", 32'h0, {31'h0, drive.power_stage_en});
		stop_done = 1'b0;
		cw(16'h0006, 16'h28);
		cw(16'h0080, 16'h60);
		masked_error = 1'b1;
		repeat (3) @(negedge core_clk);
		masked_error = 1'b0;
		chk("status", 32'h28, {16'h0, status_word & 16'h006f});
		cw(16'h0080, 16'h28);
		cw(16'h0000, 16'h28);
		cw(16'h0080, 16'h60);
		od(1'b1, 16'h605c, 8'h00, 32'h1, 1'b0);
		cw(16'h0006, 16'h21);
		cw(16'h0007, 16'h23);
		cw(16'h000f, 16'h27);
		cw(16'h0007, 16'h27);
		chk("stop", 32'h1, {31'h0, drive.controlled_stop});
		chk("flush", 32'h1, {31'h0, drive.job_flush});
		stop_done = 1'b1;
		@(negedge core_clk);
		stop_done = 1'b0;
		chk("status", 32'h23, {16'h0, status_word & 16'h006f});
		chk("stage", 32'h0, {31'h0, drive.power_stage_en});
		print_verdict();
	end
endmodule
`default_nettype wire
